// >>> shared/tpo_pkg.sv
// Purpose: shared constants of the timed pattern output unit
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes:   sixteen pins in four groups of four
package tpo_pkg;
  localparam int unsigned PIN_W       = 16;
  localparam int unsigned GROUP_W     = 4;
  localparam int unsigned GROUP_N     = 4;
  localparam int unsigned CHAN_N      = 4;
  localparam int unsigned SEL_W       = 2;
  localparam int unsigned ADR_W       = 8;
  localparam int unsigned DAT_W       = 32;
  localparam int unsigned SEL_BYTES   = 4;

  localparam logic [7:0]  OFS_PORT_DIR    = 8'h00;
  localparam logic [7:0]  OFS_NEXT_EN     = 8'h04;
  localparam logic [7:0]  OFS_PORT_DATA   = 8'h08;
  localparam logic [7:0]  OFS_NEXT_VALUE  = 8'h0C;
  localparam logic [7:0]  OFS_TRIG_SEL    = 8'h10;
  localparam logic [7:0]  OFS_GROUP_MODE  = 8'h14;
  localparam logic [7:0]  OFS_PIN_LEVEL   = 8'h18;

  localparam logic [15:0] RST_PORT_DIR    = 16'h0000;
  localparam logic [15:0] RST_NEXT_EN     = 16'h0000;
  localparam logic [15:0] RST_PORT_DATA   = 16'h0000;
  localparam logic [15:0] RST_NEXT_VALUE  = 16'h0000;
  localparam logic [7:0]  RST_TRIG_SEL    = 8'hFF;
  localparam logic [3:0]  RST_GROUP_MODE  = 4'h0;
  localparam logic [3:0]  MODE_RSVD_READ  = 4'hF;
  localparam logic [3:0]  MODE_RSVD_POS   = 4'h4;
endpackage

// >>> src/tpo_group.sv
// Purpose: trigger choice and transfer mask of one four-bit group
// Assumes: timer events are one-cycle pulses on core_clk_i
// Notes:   purely combinational, loads in the trigger cycle
`timescale 1ns/10ps
module tpo_group
  import tpo_pkg::*;
(
  input  wire logic [SEL_W-1:0]   trig_sel_i,
  input  wire logic               nonoverlap_i,
  input  wire logic [CHAN_N-1:0]  match_a_i,
  input  wire logic [CHAN_N-1:0]  match_b_i,
  input  wire logic [CHAN_N-1:0]  capture_a_i,
  input  wire logic [CHAN_N-1:0]  capture_mode_i,
  input  wire logic [GROUP_W-1:0] next_enable_i,
  input  wire logic [GROUP_W-1:0] next_value_i,
  output logic      [GROUP_W-1:0] load_o
);
  logic event_a;
  logic event_b;

  always_comb begin
    if (capture_mode_i[trig_sel_i]) begin
      event_a = capture_a_i[trig_sel_i];
    end else begin
      event_a = match_a_i[trig_sel_i];
    end
    event_b = match_b_i[trig_sel_i];
  end

  always_comb begin
    load_o = '0;
    if (event_a) begin
      load_o = next_enable_i;
    end else if (event_b && nonoverlap_i) begin
      load_o = next_enable_i & ~next_value_i;
    end
  end
endmodule

// >>> src/tpo_sync.sv
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs are asynchronous to core_clk_i
// Notes:   first stage is read by the second stage only
`timescale 1ns/10ps
module tpo_sync #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             core_clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule

// >>> src/tpo_top.sv
// Purpose: timed pattern output unit with Wishbone register slave
// Assumes: timer events and alternate pin functions on core_clk_i
// Notes:   pin levels are synchronised before reading
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module tpo_top
  import tpo_pkg::*;
(
  input  wire logic                 core_clk_i,
  input  wire logic                 rstn_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [ADR_W-1:0]     wb_adr_i,
  input  wire logic [SEL_BYTES-1:0] wb_sel_i,
  input  wire logic [DAT_W-1:0]     wb_dat_i,
  output logic      [DAT_W-1:0]     wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic [CHAN_N-1:0]    match_a_i,
  input  wire logic [CHAN_N-1:0]    match_b_i,
  input  wire logic [CHAN_N-1:0]    capture_a_i,
  input  wire logic [CHAN_N-1:0]    capture_mode_i,
  input  wire logic [PIN_W-1:0]     alt_enable_i,
  input  wire logic [PIN_W-1:0]     alt_data_i,
  input  wire logic [PIN_W-1:0]     pin_i,
  output logic      [PIN_W-1:0]     pin_o,
  output logic      [PIN_W-1:0]     pin_oe_o,
  output logic      [PIN_W-1:0]     pattern_active_o
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and wires

  logic [PIN_W-1:0]       port_direction;
  logic [PIN_W-1:0]       next_enable;
  logic [PIN_W-1:0]       port_data;
  logic [PIN_W-1:0]       next_value;
  logic [2*GROUP_N-1:0]   trigger_select_reg;
  logic [GROUP_N-1:0]     group_mode_reg;
  logic [PIN_W-1:0]       pin_level;
  logic [PIN_W-1:0]       load_mask;
  logic [PIN_W-1:0]       byte_mask;
  logic [PIN_W-1:0]       data_write_mask;
  logic [PIN_W-1:0]       next_port_data;
  logic [DAT_W-1:0]       next_rdata;
  logic                   access;
  logic                   write_en;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  tpo_sync #(
    .WIDTH (PIN_W)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .async_i    (pin_i),
    .sync_o     (pin_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // per-group trigger units

  generate
    for (genvar g = 0; g < GROUP_N; g++) begin : g_group
      tpo_group u_group (
        .trig_sel_i         (trigger_select_reg[SEL_W*g +: SEL_W]),
        .nonoverlap_i       (group_mode_reg[g]),
        .match_a_i          (match_a_i),
        .match_b_i          (match_b_i),
        .capture_a_i        (capture_a_i),
        .capture_mode_i     (capture_mode_i),
        .next_enable_i      (next_enable[GROUP_W*g +: GROUP_W]),
        .next_value_i       (next_value[GROUP_W*g +: GROUP_W]),
        .load_o             (load_mask[GROUP_W*g +: GROUP_W])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  assign access    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign write_en  = access && wb_we_i;
  assign byte_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= access;
    end
  end

  always_comb begin
    next_rdata = '0;
    if (wb_adr_i == OFS_PORT_DIR) begin
      next_rdata[PIN_W-1:0] = port_direction;
    end else if (wb_adr_i == OFS_NEXT_EN) begin
      next_rdata[PIN_W-1:0] = next_enable;
    end else if (wb_adr_i == OFS_PORT_DATA) begin
      next_rdata[PIN_W-1:0] = port_data;
    end else if (wb_adr_i == OFS_NEXT_VALUE) begin
      next_rdata[PIN_W-1:0] = next_value;
    end else if (wb_adr_i == OFS_TRIG_SEL) begin
      next_rdata[2*GROUP_N-1:0] = trigger_select_reg;
    end else if (wb_adr_i == OFS_GROUP_MODE) begin
      next_rdata[7:0] = {MODE_RSVD_READ, group_mode_reg};
    end else if (wb_adr_i == OFS_PIN_LEVEL) begin
      next_rdata[PIN_W-1:0] = pin_level;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_dat_o <= '0;
    end else if (access && !wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port_direction <= RST_PORT_DIR;
    end else if (write_en && wb_adr_i == OFS_PORT_DIR) begin
      port_direction <= (port_direction & ~byte_mask) | (wb_dat_i[PIN_W-1:0] & byte_mask);
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      next_enable <= RST_NEXT_EN;
    end else if (write_en && wb_adr_i == OFS_NEXT_EN) begin
      next_enable <= (next_enable & ~byte_mask) | (wb_dat_i[PIN_W-1:0] & byte_mask);
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      next_value <= RST_NEXT_VALUE;
    end else if (write_en && wb_adr_i == OFS_NEXT_VALUE) begin
      next_value <= (next_value & ~byte_mask) | (wb_dat_i[PIN_W-1:0] & byte_mask);
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trigger_select_reg <= RST_TRIG_SEL;
    end else if (write_en && wb_adr_i == OFS_TRIG_SEL && wb_sel_i[0]) begin
      trigger_select_reg <= wb_dat_i[2*GROUP_N-1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      group_mode_reg <= RST_GROUP_MODE;
    end else if (write_en && wb_adr_i == OFS_GROUP_MODE && wb_sel_i[0]) begin
      group_mode_reg <= wb_dat_i[GROUP_N-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port data register

  always_comb begin
    data_write_mask = '0;
    if (write_en && wb_adr_i == OFS_PORT_DATA) begin
      data_write_mask = byte_mask & ~(next_enable & ~port_direction);
    end
    next_port_data = (port_data & ~data_write_mask) | (wb_dat_i[PIN_W-1:0] & data_write_mask);
    next_port_data = (next_port_data & ~load_mask) | (next_value & load_mask);
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port_data <= RST_PORT_DATA;
    end else begin
      port_data <= next_port_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_o            <= '0;
      pin_oe_o         <= '0;
      pattern_active_o <= '0;
    end else begin
      pin_o            <= (alt_enable_i & alt_data_i) | (~alt_enable_i & port_data);
      pin_oe_o         <= alt_enable_i | port_direction;
      pattern_active_o <= ~alt_enable_i & port_direction & next_enable;
    end
  end

endmodule

// >>> verification/tpo_timer_model.sv
// Purpose: timer channel events for the pattern unit
// Assumes: one-cycle pulses on core_clk_i
// Notes: commanded by the bench
`timescale 1ns/10ps
module tpo_timer_model
  import tpo_pkg::*;
(
  input  wire logic              core_clk_i,
  output logic      [CHAN_N-1:0] match_a_o = '0,
  output logic      [CHAN_N-1:0] match_b_o = '0,
  output logic      [CHAN_N-1:0] capture_a_o = '0,
  output logic      [CHAN_N-1:0] cap_mode_o = '0
);
  // event pulse, kind bit0 a, bit1 b, bit2 capture
  task automatic fire(input logic [2:0] kind, input logic [1:0] ch);
    logic [CHAN_N-1:0] hot;
    hot = 4'h1 << ch;
    @(posedge core_clk_i);
    match_a_o <= kind[0] ? hot : 4'h0;
    match_b_o <= kind[1] ? hot : 4'h0;
    capture_a_o <= kind[2] ? hot : 4'h0;
    @(posedge core_clk_i);
    match_a_o <= 4'h0;
    match_b_o <= 4'h0;
    capture_a_o <= 4'h0;
  endtask
  task automatic set_cap(input logic [3:0] m);
    @(posedge core_clk_i);
    cap_mode_o <= m;
  endtask
endmodule

// >>> verification/tpo_top_asserts.sv
// Purpose: port checks of the pattern output unit
// Assumes: one clock, async active-low reset
// Notes: bound to every tpo_top instance
`timescale 1ns/10ps
module tpo_top_asserts
  import tpo_pkg::*;
(
  input wire logic              core_clk_i,
  input wire logic              rstn_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [DAT_W-1:0]  wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic [CHAN_N-1:0] match_a_i,
  input wire logic [CHAN_N-1:0] match_b_i,
  input wire logic [CHAN_N-1:0] capture_a_i,
  input wire logic [PIN_W-1:0]  alt_enable_i,
  input wire logic [PIN_W-1:0]  alt_data_i,
  input wire logic [PIN_W-1:0]  pin_o,
  input wire logic [PIN_W-1:0]  pin_oe_o,
  input wire logic [PIN_W-1:0]  pattern_active_o
);
  wire req = wb_cyc_i & wb_stb_i;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////////
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ACK_LAT: assert property (req && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  AST_ACK_CAUSE: assert property (!req |=> !wb_ack_o) else $error("ack without request");
  AST_RD_HOLD: assert property (!(req && !wb_we_i && !wb_ack_o) |=> $stable(wb_dat_o))
    else $error("read data moved");
  AST_OE_ALT: assert property ((~pin_oe_o & $past(alt_enable_i)) == '0)
    else $error("alt pin not driven");
  AST_ALT_VAL: assert property ((pin_o & $past(alt_enable_i)) ==
    ($past(alt_data_i) & $past(alt_enable_i))) else $error("alt value lost");
  AST_PAT_ALT: assert property ((pattern_active_o & $past(alt_enable_i)) == '0)
    else $error("pattern on taken pin");
  AST_PAT_OE: assert property ((pattern_active_o & ~pin_oe_o) == '0)
    else $error("pattern pin not driven");
  AST_PIN_HOLD: assert property (!(|{match_a_i, match_b_i, capture_a_i}) && !req &&
    !(|$past({match_a_i, match_b_i, capture_a_i})) && !$past(req) &&
    $stable(alt_enable_i) && $stable(alt_data_i) |=> $stable(pin_o))
    else $error("pin moved without cause");
endmodule
bind tpo_top tpo_top_asserts chk (.core_clk_i, .rstn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_dat_o, .wb_ack_o, .match_a_i, .match_b_i, .capture_a_i, .alt_enable_i, .alt_data_i,
  .pin_o, .pin_oe_o, .pattern_active_o);

// >>> verification/tpo_top_test.sv
// Purpose: self-checking bench of the pattern output unit
// Assumes: Wishbone classic master, timer model
// Notes: undriven pins pulled low
`timescale 1ns/10ps
module tpo_top_test;
  import tpo_pkg::*;
  logic core_clk_i = 0, rstn_i = 0, cyc = 0, stb = 0, we = 0, ack;
  logic [7:0] adr = '0;
  logic [31:0] dat = '0, rdat;
  logic [15:0] alt_en = '0, alt_dat = '0, pin_o, pin_oe, pat, d, nv;
  logic [3:0] ma, mb, ca, cm;
  logic [31:0] q[$];
  int miscompares = 0, num_checks = 0, seed = 5, cycles = 0;
  tpo_timer_model tmr (.core_clk_i, .match_a_o(ma), .match_b_o(mb), .capture_a_o(ca),
    .cap_mode_o(cm));
  tpo_top dut (.core_clk_i, .rstn_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .match_a_i(ma), .match_b_i(mb), .capture_a_i(ca), .capture_mode_i(cm),
    .alt_enable_i(alt_en), .alt_data_i(alt_dat), .pin_i(pin_o & pin_oe), .pin_o,
    .pin_oe_o(pin_oe), .pattern_active_o(pat));
  initial forever #2.5 core_clk_i = ~core_clk_i;
  ////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, v};
    do @(posedge core_clk_i); while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    bus(1'b1, a, {16'h0000, v});
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    q.push_back({16'h0000, e});
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic pins(input logic [15:0] v, input logic [15:0] oe, input logic [15:0] p);
    repeat (2) @(posedge core_clk_i);
    #1;
    check("pin_o", v, pin_o);
    check("pin_oe_o", oe, pin_oe);
    check("pattern_active_o", p, pat);
  endtask
  always @(posedge core_clk_i) if (ack === 1'b1 && !we) check("wb_dat_o", q.pop_front(), rdat);
  always @(posedge core_clk_i) if (++cycles == 20000) begin
    miscompares++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge core_clk_i);
    rstn_i <= 1;
    rd(8'h10, 16'h00FF);
    rd(8'h14, 16'h00F0);
    rd(8'h40, 16'h0000);
    wr(8'h14, 16'h00FF);
    rd(8'h14, 16'h00FF);
    wr(8'h14, 16'h0000);
    $display("test registers done");
    wr(8'h08, 16'h1234);
    wr(8'h00, 16'h0FFF);
    wr(8'h04, 16'hFFFF);
    pins(16'h1234, 16'h0FFF, 16'h0FFF);
    wr(8'h08, 16'hFFFF);
    d = 16'h1FFF;
    rd(8'h08, d);
    for (int c = 0; c < 4; c++) begin
      wr(8'h10, {8'h00, {4{c[1:0]}}});
      nv = $random(seed);
      wr(8'h0C, nv);
      tmr.fire(3'b001, c[1:0] ^ 2'b01);
      rd(8'h08, d);
      tmr.fire(3'b001, c[1:0]);
      d = nv;
      rd(8'h08, d);
      pins(d, 16'h0FFF, 16'h0FFF);
    end
    $display("test normal done");
    tmr.set_cap(4'h8);
    nv = $random(seed);
    wr(8'h0C, nv);
    tmr.fire(3'b001, 2'd3);
    rd(8'h08, d);
    tmr.fire(3'b100, 2'd3);
    d = nv;
    rd(8'h08, d);
    tmr.set_cap(4'h0);
    wr(8'h14, 16'h0001);
    nv = $random(seed);
    wr(8'h0C, nv);
    tmr.fire(3'b010, 2'd3);
    d[3:0] = d[3:0] & nv[3:0];
    rd(8'h08, d);
    tmr.fire(3'b001, 2'd3);
    d = nv;
    rd(8'h08, d);
    $display("test nonoverlap done");
    @(posedge core_clk_i);
    alt_en <= 16'h00FF;
    alt_dat <= $random(seed);
    nv = $random(seed);
    wr(8'h0C, nv);
    tmr.fire(3'b001, 2'd3);
    d = nv;
    rd(8'h08, d);
    pins({d[15:8], alt_dat[7:0]}, 16'h0FFF, 16'h0F00);
    rd(8'h18, {d[15:8], alt_dat[7:0]} & 16'h0FFF);
    $display("test shared pins done");
    finish_test();
  end
endmodule
